// ---- src/cifl_cfg.svh ----
// constants of the core interrupt flag logic: register indices, bit positions,
// reset values and fixed codes. assumes inclusion by bare name from src/.
`ifndef CIFL_CFG_SVH
`define CIFL_CFG_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CIFL_IDX_ICM 8'h0B
`define CIFL_IDX_PF1 8'h0C
`define CIFL_IDX_PF2 8'h0D
`define CIFL_IDX_OPT 8'h81
`define CIFL_IDX_PE1 8'h8C
`define CIFL_IDX_PE2 8'h8D
`define CIFL_IDX_MASK 8'hA0
`define CIFL_IDX_STAT 8'hA1

// ----------------------------------------------------------------------------
// int_control_main fields and option field
// ----------------------------------------------------------------------------
`define CIFL_GIE 7
`define CIFL_PERIPHERAL_IRQ_ENABLE 6
`define CIFL_TIMER_WRAP_ENABLE 5
`define CIFL_EXT_PIN_ENABLE 4
`define CIFL_PORT_CHANGE_ENABLE 3
`define CIFL_TIMER_WRAP_FLAG 2
`define CIFL_EXT_PIN_FLAG 1
`define CIFL_PORT_CHANGE_FLAG 0
`define CIFL_EDGE_POL 6

// ----------------------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------------------
`define CIFL_ICM_RST 8'h00
`define CIFL_PF_RST 8'h00
`define CIFL_PE_RST 8'h00
`define CIFL_PF2_IMPL 8'hF5
`define CIFL_OPT_IMPL 8'h40
`define CIFL_OPT_RST 8'h40
`define CIFL_MASK_RST 8'h00

// ----------------------------------------------------------------------------
// fixed codes
// ----------------------------------------------------------------------------
`define CIFL_VECTOR 16'h0004
`define CIFL_TMR_TOP 8'hFF
`define CIFL_TMR_BOT 8'h00
`define CIFL_Q1 2'h0
`define CIFL_Q2 2'h1
`define CIFL_Q3 2'h2
`define CIFL_Q4 2'h3

`endif

// ---- src/cifl_pkg.sv ----
// types shared by the core interrupt flag logic.
// assumes cifl_cfg.svh for all numeric constants.
package cifl_pkg;

    // sequencer state, one-hot
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_PEND = 3'b010,
        ST_SLEEP = 3'b100
    } cifl_state_t;

    // strobes from the processor core sequencer
    typedef struct packed {
        logic sleep_enter;
        logic return_from_irq;
        logic port_read;
    } cifl_core_in_t;

    // answers to the processor core sequencer
    typedef struct packed {
        logic irq_request;
        logic wake;
        logic vector_load;
        logic stack_push;
        logic sleeping;
        logic [15:0] vector_addr;
    } cifl_core_out_t;

endpackage

// ---- src/cifl_pin_sync.sv ----
// three-stage input synchroniser with agreement filter.
// assumes inputs arrive asynchronously to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cifl_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // pins in, filtered level out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("cifl_pin_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a level counts only once the second and third stages agree
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            level_out <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    level_out[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- src/cifl_top.sv ----
// core interrupt flag logic: flags, enables, gating, sleep wake-up, vectoring.
// assumes an Avalon-MM master on ref_clk and a core sequencer that issues
// one-cycle strobes and follows the vector_load / stack_push pulses.
//
// Contract
// R1: pin edge polarity chosen by option bit 6
// R2: selected pin edge sets ext_pin_flag
// R3: ext_pin_enable low blocks pin request only
// R4: service routine clears ext_pin_flag before re-enable
// R5: pin wakes sleep if enabled before sleep
// R6: after wake vector only when global enable
// R7: timer FFh to 00h sets timer_wrap_flag
// R8: timer_wrap_enable gates timer request
// R9: monitored port change sets port_change_flag
// R10: port_change_enable gates port request
// R11: per-pin mask selects monitored port pins
// R12: change during Q2 port read may vanish
// R13: ext_pin_flag set only in Q4-Q1
// R14: latency independent of instruction length
// R15: unimplemented periph bits read zero
// R16: only return address pushed on service
// R17: software saves working and status registers
// R18: global enable gates all, cleared on reset
// R19: service clears global enable, pushes, vectors
// R20: flags set regardless of enable bits
// R21: return_from_irq sets global enable again
// R22: request is global AND enabled flag pairs
// R23: enabled peripheral flag wakes regardless global
`timescale 1ns/1ps
`default_nettype none
`include "cifl_cfg.svh"
module cifl_top import cifl_pkg::*; #(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // avalon-mm register slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // pins and event sources
    input wire logic ext_irq_pin,
    input wire logic [PORT_W-1:0] port_pins,
    input wire logic [7:0] timer_zero_count,
    input wire logic [7:0] periph_evt_1,
    input wire logic [7:0] periph_evt_2,
    // core sequencer
    input wire cifl_core_in_t core_in,
    output cifl_core_out_t core_out
);

    initial begin
        if (PORT_W < 1 || PORT_W > 8) begin
            $error("cifl_top: PORT_W must lie in 1..8");
        end
    end

    // ------------------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------------------
    logic [1:0] phase_reg;
    logic q1, q2, q4;
    logic ext_level, ext_prev_reg, ext_edge, ext_pend_reg, ext_set;
    logic [PORT_W-1:0] port_level, port_latch_reg;
    logic port_change;
    logic [7:0] tmr_prev_reg;
    logic tmr_wrap;
    logic [7:0] icm_reg, icm_next;
    logic [7:0] pf1_reg, pf2_reg, pe1_reg, pe2_reg, opt_reg, mask_reg;
    logic periph_pair, any_pair, irq_req, wake_cond, take;
    logic ext_pin_enable_at_sleep_reg;
    cifl_state_t state_reg;
    logic wait_reg;
    logic [7:0] idx;
    logic wr_hit, rd_hit;
    logic [7:0] rd_data;

    assign q1 = (phase_reg == `CIFL_Q1);
    assign q2 = (phase_reg == `CIFL_Q2);
    assign q4 = (phase_reg == `CIFL_Q4);

    // ------------------------------------------------------------------------
    // instruction-cycle phase divider
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= `CIFL_Q1;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    cifl_pin_sync #(.WIDTH(1)) u_ext_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(ext_irq_pin),
        .level_out(ext_level)
    );

    cifl_pin_sync #(.WIDTH(PORT_W)) u_port_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(port_pins),
        .level_out(port_level)
    );

    // ------------------------------------------------------------------------
    // external pin edge detection
    // ------------------------------------------------------------------------
    assign ext_edge = opt_reg[`CIFL_EDGE_POL] ? (ext_level & ~ext_prev_reg)
                                              : (~ext_level & ext_prev_reg); // R1
    // an edge seen in Q2/Q3 waits for the Q4-Q1 window
    assign ext_set = (ext_edge | ext_pend_reg) & (q4 | q1); // R13

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_prev_reg <= 1'b0;
            ext_pend_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_level;
            ext_pend_reg <= (ext_pend_reg | ext_edge) & ~(q4 | q1);
        end
    end

    // ------------------------------------------------------------------------
    // timer wrap detection
    // ------------------------------------------------------------------------
    assign tmr_wrap = (tmr_prev_reg == `CIFL_TMR_TOP) && (timer_zero_count == `CIFL_TMR_BOT); // R7

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_prev_reg <= `CIFL_TMR_BOT;
        end else begin
            tmr_prev_reg <= timer_zero_count;
        end
    end

    // ------------------------------------------------------------------------
    // port change detection
    // ------------------------------------------------------------------------
    // the latch follows the pins only on a port read in Q2; a pin that moves in
    // that same cycle still sets port_change_flag, as the flag loads with the latch
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_latch_reg <= '0;
        end else if (core_in.port_read && q2) begin
            port_latch_reg <= port_level; // R12
        end
    end

    assign port_change = |((port_level ^ port_latch_reg) & mask_reg[PORT_W-1:0]); // R9 R11

    // ------------------------------------------------------------------------
    // avalon slave handshake
    // ------------------------------------------------------------------------
    assign idx = avs_address[9:2];
    assign wr_hit = avs_write && !wait_reg && avs_byteenable[0];
    assign rd_hit = (avs_read || avs_write) && wait_reg;
    assign avs_waitrequest = wait_reg;

    // one wait cycle: waitrequest drops for one cycle, then returns high
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !rd_hit;
        end
    end

    always_comb begin
        case (idx)
            `CIFL_IDX_ICM: rd_data = icm_reg;
            `CIFL_IDX_PF1: rd_data = pf1_reg;
            `CIFL_IDX_PF2: rd_data = pf2_reg & `CIFL_PF2_IMPL; // R15
            `CIFL_IDX_OPT: rd_data = opt_reg;
            `CIFL_IDX_PE1: rd_data = pe1_reg;
            `CIFL_IDX_PE2: rd_data = pe2_reg & `CIFL_PF2_IMPL; // R15
            `CIFL_IDX_MASK: rd_data = mask_reg;
            `CIFL_IDX_STAT: rd_data = {3'h0, ext_pend_reg, irq_req, state_reg};
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            avs_readdata <= {24'h00_0000, rd_data};
        end
    end

    // ------------------------------------------------------------------------
    // int_control_main
    // ------------------------------------------------------------------------
    always_comb begin
        icm_next = icm_reg;
        if (wr_hit && idx == `CIFL_IDX_ICM) begin
            icm_next = avs_writedata[7:0];
        end
        // hardware sets win over a software clear in the same cycle
        if (ext_set) begin
            icm_next[`CIFL_EXT_PIN_FLAG] = 1'b1; // R2 R20
        end
        if (tmr_wrap) begin
            icm_next[`CIFL_TIMER_WRAP_FLAG] = 1'b1; // R7 R20
        end
        if (port_change) begin
            icm_next[`CIFL_PORT_CHANGE_FLAG] = 1'b1; // R9 R20
        end
        if (core_in.return_from_irq) begin
            icm_next[`CIFL_GIE] = 1'b1; // R21
        end
        if (take) begin
            icm_next[`CIFL_GIE] = 1'b0; // R19
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            icm_reg <= `CIFL_ICM_RST; // R18
        end else begin
            icm_reg <= icm_next;
        end
    end

    // ------------------------------------------------------------------------
    // peripheral flags, enables, option and mask
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pf1_reg <= `CIFL_PF_RST;
            pf2_reg <= `CIFL_PF_RST;
        end else begin
            pf1_reg <= ((wr_hit && idx == `CIFL_IDX_PF1) ? avs_writedata[7:0] : pf1_reg) | periph_evt_1;
            pf2_reg <= (((wr_hit && idx == `CIFL_IDX_PF2) ? avs_writedata[7:0] : pf2_reg) | periph_evt_2)
                       & `CIFL_PF2_IMPL; // R15 R20
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pe1_reg <= `CIFL_PE_RST;
            pe2_reg <= `CIFL_PE_RST;
            opt_reg <= `CIFL_OPT_RST;
            mask_reg <= `CIFL_MASK_RST;
        end else if (wr_hit) begin
            case (idx)
                `CIFL_IDX_PE1: pe1_reg <= avs_writedata[7:0];
                `CIFL_IDX_PE2: pe2_reg <= avs_writedata[7:0] & `CIFL_PF2_IMPL; // R15
                `CIFL_IDX_OPT: opt_reg <= avs_writedata[7:0] & `CIFL_OPT_IMPL;
                `CIFL_IDX_MASK: mask_reg <= avs_writedata[7:0]; // R11
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // request gating and wake-up
    // ------------------------------------------------------------------------
    assign periph_pair = icm_reg[`CIFL_PERIPHERAL_IRQ_ENABLE] & (|((pf1_reg & pe1_reg) | (pf2_reg & pe2_reg)));
    assign any_pair = (icm_reg[`CIFL_TIMER_WRAP_ENABLE] & icm_reg[`CIFL_TIMER_WRAP_FLAG])   // R8
                    | (icm_reg[`CIFL_EXT_PIN_ENABLE] & icm_reg[`CIFL_EXT_PIN_FLAG])   // R3
                    | (icm_reg[`CIFL_PORT_CHANGE_ENABLE] & icm_reg[`CIFL_PORT_CHANGE_FLAG])   // R10
                    | periph_pair;
    assign irq_req = icm_reg[`CIFL_GIE] & any_pair; // R22 R18
    // wake ignores the global enable; the pin needs its enable from before sleep
    assign wake_cond = (ext_pin_enable_at_sleep_reg & icm_reg[`CIFL_EXT_PIN_FLAG]) // R5
                     | (icm_reg[`CIFL_TIMER_WRAP_ENABLE] & icm_reg[`CIFL_TIMER_WRAP_FLAG])
                     | (icm_reg[`CIFL_PORT_CHANGE_ENABLE] & icm_reg[`CIFL_PORT_CHANGE_FLAG])
                     | periph_pair; // R23
    // vectoring waits for a Q4 boundary, never for the instruction length
    assign take = (state_reg == ST_PEND) && q4 && icm_reg[`CIFL_GIE]; // R14

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_pin_enable_at_sleep_reg <= 1'b0;
        end else if (core_in.sleep_enter && state_reg == ST_RUN) begin
            ext_pin_enable_at_sleep_reg <= icm_reg[`CIFL_EXT_PIN_ENABLE];
        end
    end

    // ------------------------------------------------------------------------
    // service sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (core_in.sleep_enter) begin
                        state_reg <= ST_SLEEP;
                    end else if (irq_req && q4) begin
                        state_reg <= ST_PEND;
                    end
                end
                ST_PEND: begin
                    // a cleared global enable drops the request; the flag stays
                    if (!icm_reg[`CIFL_GIE] || q4) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_SLEEP: begin
                    if (wake_cond) begin
                        state_reg <= icm_reg[`CIFL_GIE] ? ST_PEND : ST_RUN; // R6
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_out.irq_request <= 1'b0;
            core_out.wake <= 1'b0;
            core_out.vector_load <= 1'b0;
            core_out.stack_push <= 1'b0;
            core_out.sleeping <= 1'b0;
            core_out.vector_addr <= `CIFL_VECTOR;
        end else begin
            core_out.irq_request <= irq_req;
            core_out.wake <= (state_reg == ST_SLEEP) && wake_cond;
            core_out.vector_load <= take; // R19
            core_out.stack_push <= take; // R16
            core_out.sleeping <= (state_reg == ST_SLEEP && !wake_cond) ||
                                 (state_reg == ST_RUN && core_in.sleep_enter);
            core_out.vector_addr <= `CIFL_VECTOR;
        end
    end

    chk_wait_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest held low beyond one cycle");

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    chk_rise_sets_flag: assert property ( // R1
        (opt_reg[`CIFL_EDGE_POL] && ext_level && !ext_prev_reg && (q4 || q1)) |=> icm_reg[`CIFL_EXT_PIN_FLAG])
        else $error("rising pin edge did not set ext_pin_flag");

    chk_flag_window: assert property ( // R13
        ($rose(icm_reg[`CIFL_EXT_PIN_FLAG]) && !$past(wr_hit)) |-> ($past(phase_reg) == `CIFL_Q4 ||
                                                              $past(phase_reg) == `CIFL_Q1))
        else $error("ext_pin_flag set outside Q4-Q1");

    chk_timer_wrap: assert property ( // R7
        tmr_wrap |=> icm_reg[`CIFL_TIMER_WRAP_FLAG])
        else $error("timer wrap did not set timer_wrap_flag");

    chk_port_change: assert property ( // R9
        port_change |=> icm_reg[`CIFL_PORT_CHANGE_FLAG])
        else $error("port change did not set port_change_flag");

    chk_gie_blocks: assert property ( // R18
        !icm_reg[`CIFL_GIE] |=> !core_out.irq_request)
        else $error("request raised with global enable clear");

    chk_ext_pin_enable_blocks: assert property ( // R3
        (icm_reg[`CIFL_EXT_PIN_FLAG] && !icm_reg[`CIFL_EXT_PIN_ENABLE] && !icm_reg[`CIFL_TIMER_WRAP_FLAG] && !icm_reg[`CIFL_PORT_CHANGE_FLAG]
         && !periph_pair) |=> !core_out.irq_request)
        else $error("disabled pin flag raised a request");

    chk_vector_clears: assert property ( // R19
        core_out.vector_load |-> (!icm_reg[`CIFL_GIE] && core_out.stack_push
                                  && core_out.vector_addr == `CIFL_VECTOR))
        else $error("vectoring without push or with global enable left set");

    chk_fixed_latency: assert property ( // R14
        (state_reg == ST_RUN && irq_req && q4 && !core_in.sleep_enter) ##1 icm_reg[`CIFL_GIE] [*4]
        |=> core_out.vector_load)
        else $error("vector not issued one instruction cycle after request");

    chk_return_from_irq_sets: assert property ( // R21
        (core_in.return_from_irq && state_reg == ST_RUN) |=> icm_reg[`CIFL_GIE])
        else $error("return_from_irq did not set global enable");

    chk_pin_wakes: assert property ( // R5
        (state_reg == ST_SLEEP && ext_pin_enable_at_sleep_reg && icm_reg[`CIFL_EXT_PIN_FLAG]) |=> core_out.wake)
        else $error("enabled pin flag did not wake the core");

    chk_wake_nogie: assert property ( // R6
        (state_reg == ST_SLEEP && wake_cond && !icm_reg[`CIFL_GIE]) |=> state_reg == ST_RUN [*2])
        else $error("wake without global enable went to the vector");

    chk_unimpl_zero: assert property ( // R15
        ((pf2_reg | pe2_reg) & ~`CIFL_PF2_IMPL) == 8'h00)
        else $error("unimplemented peripheral bit set");

endmodule
`default_nettype wire

// ---- testbench/cifl_core_model.sv ----
// core sequencer model: issues sleep, port-read and return strobes.
// assumes cifl_pkg and one-cycle vector_load pulses from the flag logic.
`timescale 1ns/1ps
`default_nettype none
module cifl_core_model import cifl_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link to the flag logic
    input wire cifl_core_out_t core_out,
    output cifl_core_in_t core_in,
    // bench commands
    input wire logic go_sleep,
    input wire logic isr_done,
    input wire logic rd_req,
    output int vec_count
);
    logic in_isr;
    // return_from_irq held back until the bench has cleared the flag
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_in <= '0;
            in_isr <= 1'b0;
            vec_count <= 0;
        end else begin
            core_in.sleep_enter <= go_sleep;
            core_in.port_read <= rd_req;
            core_in.return_from_irq <= in_isr && isr_done;
            if (in_isr && isr_done)
                in_isr <= 1'b0;
            if (core_out.vector_load) begin
                in_isr <= 1'b1;
                vec_count <= vec_count + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for cifl_top: bus tasks and one task per scenario.
// assumes cifl_core_model on the core link and a 100 MHz ref_clk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cifl_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0;
    logic [9:0] avs_address = '0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic avs_waitrequest, ext_irq_pin = 1'b0;
    logic [7:0] port_pins = 8'h00, timer_zero_count = 8'h00, periph_evt = 8'h00;
    logic go_sleep = 1'b0, isr_done = 1'b0, rd_req = 1'b0;
    cifl_core_in_t core_in;
    cifl_core_out_t core_out;
    int vec_count, bad_count = 0, num_checks = 0, cyc = 0, v0;
    logic [7:0] rd;
    always #5 ref_clk = ~ref_clk;
    cifl_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_irq_pin),
        .port_pins(port_pins), .timer_zero_count(timer_zero_count), .periph_evt_1(periph_evt),
        .periph_evt_2(8'h00), .core_in(core_in), .core_out(core_out));
    cifl_core_model core_u (.ref_clk(ref_clk), .rst_b(rst_b), .core_out(core_out), .core_in(core_in),
        .go_sleep(go_sleep), .isr_done(isr_done), .rd_req(rd_req), .vec_count(vec_count));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // hang guard: whole run is well under 3000 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(what, {8'h00, exp}, {8'h00, rd});
    endtask
    task automatic t_reset();
        rchk("icm", 8'h0B, 8'h00);
        rchk("pf2", 8'h0D, 8'h00);
        rchk("opt", 8'h81, 8'h40);
        rchk("unmapped", 8'h55, 8'h00);
        bus(1'b1, 8'h8D, 8'hFF);
        rchk("pe2", 8'h8D, 8'hF5);
        $display("test reset done");
    endtask
    task automatic t_pin();
        @(posedge ref_clk) ext_irq_pin <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rchk("rise flag", 8'h0B, 8'h02);
        bus(1'b1, 8'h0B, 8'h82);
        repeat (2) @(posedge ref_clk);
        chk("no req", 16'h0, {15'h0, core_out.irq_request});
        bus(1'b1, 8'h0B, 8'h00);
        bus(1'b1, 8'h81, 8'h00);
        @(posedge ref_clk) ext_irq_pin <= 1'b0;
        repeat (12) @(posedge ref_clk);
        rchk("fall flag", 8'h0B, 8'h02);
        bus(1'b1, 8'h0B, 8'h00);
        @(posedge ref_clk) ext_irq_pin <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rchk("wrong edge", 8'h0B, 8'h00);
        $display("test pin done");
    endtask
    task automatic t_timer();
        @(posedge ref_clk) timer_zero_count <= 8'hFF;
        @(posedge ref_clk) timer_zero_count <= 8'h00;
        repeat (3) @(posedge ref_clk);
        rchk("wrap flag", 8'h0B, 8'h04);
        v0 = vec_count;
        bus(1'b1, 8'h0B, 8'hA4);
        for (int i = 0; i < 20 && core_out.vector_load !== 1'b1; i++) @(posedge ref_clk);
        chk("push", 16'h1, {15'h0, core_out.stack_push});
        chk("vector", 16'h0004, core_out.vector_addr);
        rchk("gie off", 8'h0B, 8'h24);
        bus(1'b1, 8'h0B, 8'h20);
        @(posedge ref_clk) isr_done <= 1'b1;
        repeat (3) @(posedge ref_clk);
        isr_done <= 1'b0;
        rchk("return_from_irq", 8'h0B, 8'hA0);
        chk("one vector", 16'(v0 + 1), 16'(vec_count));
        bus(1'b1, 8'h0B, 8'h00);
        $display("test timer done");
    endtask
    task automatic t_sleep();
        v0 = vec_count;
        bus(1'b1, 8'h0B, 8'h10);
        @(posedge ref_clk) go_sleep <= 1'b1;
        @(posedge ref_clk) go_sleep <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("asleep", 16'h1, {15'h0, core_out.sleeping});
        ext_irq_pin <= 1'b0;
        for (int i = 0; i < 20 && core_out.wake !== 1'b1; i++) @(posedge ref_clk);
        chk("wake", 16'h1, {15'h0, core_out.wake});
        repeat (10) @(posedge ref_clk);
        chk("no vector", 16'(v0), 16'(vec_count));
        chk("awake", 16'h0, {15'h0, core_out.sleeping});
        bus(1'b1, 8'h0B, 8'h00);
        $display("test sleep done");
    endtask
    task automatic t_port();
        bus(1'b1, 8'hA0, 8'h01);
        @(posedge ref_clk) port_pins <= 8'h02;
        repeat (10) @(posedge ref_clk);
        rchk("masked pin", 8'h0B, 8'h00);
        port_pins <= 8'h03;
        repeat (10) @(posedge ref_clk);
        rchk("port flag", 8'h0B, 8'h01);
        @(posedge ref_clk) rd_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_req <= 1'b0;
        bus(1'b1, 8'h0B, 8'h00);
        rchk("port clear", 8'h0B, 8'h00);
        $display("test port done");
    endtask
    task automatic t_periph();
        bus(1'b1, 8'h8C, 8'h01);
        bus(1'b1, 8'h0B, 8'h40);
        @(posedge ref_clk) go_sleep <= 1'b1;
        @(posedge ref_clk) go_sleep <= 1'b0;
        repeat (2) @(posedge ref_clk);
        periph_evt <= 8'h01;
        @(posedge ref_clk) periph_evt <= 8'h00;
        for (int i = 0; i < 20 && core_out.wake !== 1'b1; i++) @(posedge ref_clk);
        chk("periph wake", 16'h1, {15'h0, core_out.wake});
        rchk("pf1 flag", 8'h0C, 8'h01);
        bus(1'b1, 8'h0C, 8'h00);
        bus(1'b1, 8'h0B, 8'h00);
        $display("test periph done");
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_pin();
        t_timer();
        t_sleep();
        t_port();
        t_periph();
        end_sim();
    end
endmodule
`default_nettype wire
